// ### rtl/rrc_pkg.sv
// Purpose: Shared constants and types for the remote run control block.
// Assumes: 50 MHz system clock, APB register access.
// Notes:   Cycle counts derive from the printed times and the clock rate.
`default_nettype none

package rrc_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ     = 50_000_000;        // System clock rate
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;     // Cycles per ms
  localparam int unsigned HOLD_MS    = 300;               // Start/clear minimum hold
  localparam int unsigned LONG_MS    = 10_000;            // Start hold at power-on
  localparam int unsigned PWRUP_MS   = 300;               // Power-on window length
  localparam int unsigned FLASH_MS   = 250;               // One flash half-slot
  localparam int          CNT_W      = 29;                // Fits 10 s of cycles

  localparam logic [CNT_W-1:0] HOLD_CYC  = CNT_W'(HOLD_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] LONG_CYC  = CNT_W'(LONG_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] PWRUP_CYC = CNT_W'(PWRUP_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] FLASH_CYC = CNT_W'(FLASH_MS * CYC_PER_MS);

  // ----------------------------------------------------------------------
  // Speed thresholds in rpm
  // ----------------------------------------------------------------------
  localparam logic [15:0] RPM_ONE   = 16'h07D0;           // 2,000
  localparam logic [15:0] RPM_TWO   = 16'h2710;           // 10,000
  localparam logic [15:0] RPM_THREE = 16'h4E20;           // 20,000
  localparam logic [15:0] RPM_CONT  = 16'h5FB4;           // 24,500
  localparam logic [15:0] RPM_TOP   = 16'h6C34;           // 27,700

  // ----------------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------------
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;           // Method select
  localparam logic [7:0]  OFS_STAT     = 8'h04;           // Live state
  localparam logic [7:0]  OFS_IRQ_STAT = 8'h08;           // Sticky events, W1C
  localparam logic [7:0]  OFS_IRQ_MASK = 8'h0C;           // Event enables
  localparam int          CTRL_METHOD  = 0;               // 0: method one, 1: two
  localparam logic        CTRL_RST     = 1'b0;
  localparam logic [3:0]  MASK_RST     = 4'h0;
  localparam int          IRQ_W        = 4;
  localparam int          IRQ_START    = 0;               // Run accepted
  localparam int          IRQ_STOP     = 1;               // Rotor drive removed
  localparam int          IRQ_FAULT    = 2;               // Failure latched
  localparam int          IRQ_CLEAR    = 3;               // Failure released

  // ----------------------------------------------------------------------
  // Input vector positions (synchroniser order)
  // ----------------------------------------------------------------------
  localparam int IN_RUN  = 0;                             // Run-request line
  localparam int IN_HOLD = 1;                             // Hold-enable line
  localparam int IN_CLR  = 2;                             // Fault-clear line
  localparam int IN_PORT = 3;                             // Parallel port select
  localparam int IN_TYPE = 4;                             // Input type select
  localparam int IN_W    = 5;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,                                     // Levitating or coasting
    ST_RUN   = 2'b01,                                     // Rotor driven
    ST_FAULT = 2'b11                                      // Latched failure
  } rrc_state_e;

  typedef struct packed {
    logic [IN_W-1:0]  sync1;
    logic [IN_W-1:0]  sync2;
    rrc_state_e       st;
    logic [CNT_W-1:0] run_cnt;
    logic [CNT_W-1:0] clr_cnt;
    logic [CNT_W-1:0] pwr_cnt;
    logic [CNT_W-1:0] flash_cnt;
    logic             pwr_win;
    logic             long_req;
    logic             armed;
    logic [2:0]       phase;
    logic             method;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [31:0]      prdata;
    logic             pslverr;
    logic             led_pwr;
    logic             led_rot_g;
    logic             led_rot_o;
    logic             led_fail_o;
    logic             led_fail_r;
  } rrc_regs_s;

endpackage : rrc_pkg

`default_nettype wire

// ### rtl/rrc_remote_ctrl.sv
// Purpose: Remote discrete run/stop/fault-clear decoder and status indicators.
// Assumes: One 50 MHz clock; pins are asynchronous; fault and speed come
//          from pump logic on the same clock.
// Notes:   Registers on APB; one level interrupt from sticky event bits.
`default_nettype none

// How it works
// - Common-linked select pin means voltage inputs asserted.
// - Method one: hold enable, then start 0.3 s.
// - Start held at power-on needs 10 s.
// - Method one stops when hold enable drops.
// - Method two: start is a level; hold ignored.
// - Restart accepted while still decelerating.
// - Abnormality latches failure, stops, blocks restart.
// - Fault clear held 0.3 s releases failure.
// - Power, rotation, failure indicators show state.
// - Rotation green flash count follows speed.
// - Rotation dark/orange; failure orange or red.
// - Inputs act only with parallel port selected.
module rrc_remote_ctrl #(
  parameter logic [rrc_pkg::CNT_W-1:0] P_HOLD_CYC  = rrc_pkg::HOLD_CYC,
  parameter logic [rrc_pkg::CNT_W-1:0] P_LONG_CYC  = rrc_pkg::LONG_CYC,
  parameter logic [rrc_pkg::CNT_W-1:0] P_PWRUP_CYC = rrc_pkg::PWRUP_CYC,
  parameter logic [rrc_pkg::CNT_W-1:0] P_FLASH_CYC = rrc_pkg::FLASH_CYC
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_sys_rst,
  // Remote connector pins, electrical level
  input  wire logic                      i_in_type_open,
  input  wire logic                      i_port_sel,
  input  wire logic                      i_run_req,
  input  wire logic                      i_hold_en,
  input  wire logic                      i_fault_clr,
  // Pump logic, same clock
  input  wire logic                      i_fault_event,
  input  wire logic                      i_warning,
  input  wire logic [1:0]                i_warn_code,
  input  wire logic [1:0]                i_fault_code,
  input  wire logic [15:0]               i_speed_rpm,
  input  wire logic                      i_normal_op,
  // APB slave
  input  wire logic                      i_psel,
  input  wire logic                      i_penable,
  input  wire logic                      i_pwrite,
  input  wire logic [rrc_pkg::ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]               i_pwdata,
  output logic [31:0]                    o_prdata,
  output logic                           o_pready,
  output logic                           o_pslverr,
  // Drive and indicators
  output logic                           o_rotor_run,
  output logic                           o_fault_latched,
  output logic                           o_led_power,
  output logic                           o_led_rot_green,
  output logic                           o_led_rot_orange,
  output logic                           o_led_fail_orange,
  output logic                           o_led_fail_red,
  output logic                           o_irq
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Lit during the first half of each of the first cnt slots
  // Phase bit 0 set marks the dark half
  function automatic logic flash_lit(input logic [2:0] ph, input logic [1:0] cnt);
    return !ph[0] && (ph[2:1] < cnt);
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  rrc_pkg::rrc_regs_s q;                       // Registered state
  rrc_pkg::rrc_regs_s d;                       // Next state
  logic [3:0]               act;               // Decoded asserted lines
  logic                     run_in;            // Run request, port-gated
  logic                     hold_in;           // Hold enable, port-gated
  logic                     clr_in;            // Fault clear, port-gated
  logic                     counting;          // Start qualifier holding
  logic                     start_ok;          // Start hold time met
  logic                     stop_req;          // Stop condition for method
  logic [rrc_pkg::CNT_W-1:0] need;             // Start hold target
  logic [rrc_pkg::IRQ_W-1:0] ev;               // Event pulses this cycle
  logic [rrc_pkg::IRQ_W-1:0] w1c;              // Software clear bits
  logic                     mapped;            // Address decodes
  logic [31:0]              rd_val;            // Read mux
  logic                     moving;            // Rotor not at standstill

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    d = q;
    ev = '0;
    w1c = '0;

    // Two flops per pin; only sync2 is decoded below
    // Only sync2 reads sync1: no metastable fan-out
    d.sync1 = {i_in_type_open, i_port_sel, i_fault_clr, i_hold_en, i_run_req};
    d.sync2 = q.sync1;

    // Open select pin: contacts pull low when closed; linked: voltage high
    act = q.sync2[3:0] ^ {4{q.sync2[rrc_pkg::IN_TYPE]}};
    run_in = act[rrc_pkg::IN_RUN] & act[rrc_pkg::IN_PORT];
    hold_in = act[rrc_pkg::IN_HOLD] & act[rrc_pkg::IN_PORT];
    clr_in = act[rrc_pkg::IN_CLR] & act[rrc_pkg::IN_PORT];

    // Power-on window, after which a start needs only the short hold
    // Counter freezes once the window closes
    if (q.pwr_win) begin
      if (q.pwr_cnt == P_PWRUP_CYC - 1'b1) begin
        d.pwr_win = 1'b0;
      end else begin
        d.pwr_cnt = q.pwr_cnt + 1'b1;
      end
    end

    // Start qualifier; method two ignores the hold line
    // Any drop restarts the count from zero
    need = q.long_req ? P_LONG_CYC : P_HOLD_CYC;
    counting = run_in && (q.method || hold_in) && q.armed
               && (q.st == rrc_pkg::ST_IDLE);
    if (!counting) begin
      d.run_cnt = '0;
      d.long_req = 1'b0;
    end else if (q.run_cnt != need) begin
      d.run_cnt = q.run_cnt + 1'b1;
      if (q.run_cnt == '0) begin
        d.long_req = q.pwr_win;
      end
    end
    start_ok = counting && (q.run_cnt == need);

    // A fresh assertion is needed after each accepted start
    if (!run_in) begin
      d.armed = 1'b1;
    end

    // Method one stops on hold; method two on the run level
    // Port deselect reads as a drop and stops too
    stop_req = q.method ? !run_in : !hold_in;

    // Run / fault sequencing
    unique case (q.st)
      rrc_pkg::ST_IDLE: begin
        // Speed is not checked, so a coasting rotor is re-driven
        if (start_ok) begin
          d.st = rrc_pkg::ST_RUN;
          d.armed = 1'b0;
          ev[rrc_pkg::IRQ_START] = 1'b1;
        end
      end
      rrc_pkg::ST_RUN: begin
        // Stop level checked every cycle
        if (stop_req) begin
          d.st = rrc_pkg::ST_IDLE;
          ev[rrc_pkg::IRQ_STOP] = 1'b1;
        end
      end
      rrc_pkg::ST_FAULT: begin
        // Restart after release needs the run line re-asserted
        d.armed = !run_in;
        // Clear must stand for the whole count
        if (!clr_in) begin
          d.clr_cnt = '0;
        end else if (q.clr_cnt == P_HOLD_CYC) begin
          d.st = rrc_pkg::ST_IDLE;
          d.clr_cnt = '0;
          ev[rrc_pkg::IRQ_CLEAR] = 1'b1;
        end else begin
          d.clr_cnt = q.clr_cnt + 1'b1;
        end
      end
      default: begin
        // Unused code 2'b10 recovers to idle
        d.st = rrc_pkg::ST_IDLE;
      end
    endcase

    // Abnormality overrides any other move
    // A live cause also holds off a release
    if (i_fault_event) begin
      d.st = rrc_pkg::ST_FAULT;
      d.clr_cnt = '0;
      ev[rrc_pkg::IRQ_FAULT] = (q.st != rrc_pkg::ST_FAULT);
      ev[rrc_pkg::IRQ_CLEAR] = 1'b0;
      ev[rrc_pkg::IRQ_STOP] = (q.st == rrc_pkg::ST_RUN);
    end

    // Flash timebase: half-slot enable pulse and phase counter
    // Eight half-slots make one pattern period
    if (q.flash_cnt == P_FLASH_CYC - 1'b1) begin
      d.flash_cnt = '0;
      d.phase = q.phase + 1'b1;
    end else begin
      d.flash_cnt = q.flash_cnt + 1'b1;
    end

    // Indicators
    // Each indicator flop lags the state a cycle
    moving = (i_speed_rpm != 16'h0000);
    d.led_pwr = 1'b1;
    d.led_rot_g = 1'b0;
    d.led_rot_o = 1'b0;
    if (q.st == rrc_pkg::ST_RUN) begin
      if (i_normal_op || i_speed_rpm >= rrc_pkg::RPM_CONT) begin
        d.led_rot_g = 1'b1;
      end else if (i_speed_rpm <= rrc_pkg::RPM_ONE) begin
        d.led_rot_g = flash_lit(q.phase, 2'd1);
      end else if (i_speed_rpm <= rrc_pkg::RPM_TWO) begin
        d.led_rot_g = flash_lit(q.phase, 2'd2);
      end else if (i_speed_rpm <= rrc_pkg::RPM_THREE) begin
        d.led_rot_g = flash_lit(q.phase, 2'd3);
      end else begin
        d.led_rot_g = !q.phase[0];
      end
    end else if (moving) begin
      d.led_rot_o = 1'b1;
    end
    // Code 0 means steady red or orange flashing in every slot
    d.led_fail_r = 1'b0;
    d.led_fail_o = 1'b0;
    if (q.st == rrc_pkg::ST_FAULT) begin
      d.led_fail_r = (i_fault_code == 2'd0) ? 1'b1 : flash_lit(q.phase, i_fault_code);
    end else if (i_warning) begin
      d.led_fail_o = (i_warn_code == 2'd0) ? !q.phase[0] : flash_lit(q.phase, i_warn_code);
    end

    // Register read mux, taken in the setup cycle
    // Unmapped offsets read zero, flag an error
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (i_paddr)
      rrc_pkg::OFS_CTRL:     rd_val[rrc_pkg::CTRL_METHOD] = q.method;
      rrc_pkg::OFS_STAT:     rd_val[4:0] = {act[rrc_pkg::IN_PORT], q.pwr_win,
                                            q.st == rrc_pkg::ST_FAULT, moving,
                                            q.st == rrc_pkg::ST_RUN};
      rrc_pkg::OFS_IRQ_STAT: rd_val[rrc_pkg::IRQ_W-1:0] = q.irq_stat;
      rrc_pkg::OFS_IRQ_MASK: rd_val[rrc_pkg::IRQ_W-1:0] = q.irq_mask;
      default:               mapped = 1'b0;
    endcase
    if (i_psel && !i_penable) begin
      d.prdata = rd_val;
      d.pslverr = !mapped;
    end

    // Writes land at the access edge
    // Live status offset is read-only
    if (i_psel && i_penable && i_pwrite && mapped) begin
      unique case (i_paddr)
        rrc_pkg::OFS_CTRL:     d.method = i_pwdata[rrc_pkg::CTRL_METHOD];
        rrc_pkg::OFS_IRQ_STAT: w1c = i_pwdata[rrc_pkg::IRQ_W-1:0];
        rrc_pkg::OFS_IRQ_MASK: d.irq_mask = i_pwdata[rrc_pkg::IRQ_W-1:0];
        default:               w1c = '0;
      endcase
    end
    // A new event wins over a same-cycle clear
    d.irq_stat = (q.irq_stat & ~w1c) | ev;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      // Zero, then the few non-zero values
      q <= '0;
      q.st <= rrc_pkg::ST_IDLE;
      q.pwr_win <= 1'b1;                       // Window opens at release
      q.armed <= 1'b1;                         // Allows start held at power-on
      q.method <= rrc_pkg::CTRL_RST;
      q.irq_mask <= rrc_pkg::MASK_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign o_prdata = q.prdata;
  assign o_pready = 1'b1;                      // Zero-wait slave
  assign o_pslverr = q.pslverr & i_psel & i_penable;
  assign o_rotor_run = (q.st == rrc_pkg::ST_RUN);
  assign o_fault_latched = (q.st == rrc_pkg::ST_FAULT);
  assign o_led_power = q.led_pwr;
  assign o_led_rot_green = q.led_rot_g;
  assign o_led_rot_orange = q.led_rot_o;
  assign o_led_fail_orange = q.led_fail_o;
  assign o_led_fail_red = q.led_fail_r;
  // Level while any unmasked event is pending
  assign o_irq = |(q.irq_stat & q.irq_mask);

endmodule // rrc_remote_ctrl

`default_nettype wire

// ### testbench/rrc_far_side.sv
// Purpose: Remote switching equipment driving the discrete pins.
// Assumes: Inputs are logical assert levels from the bench.
// Notes:   Contact wiring pulls pins low when closed.
`default_nettype none
module rrc_far_side (
  input  wire logic i_contact, // 1: contact wiring
  input  wire logic i_port,    // Port select asserted
  input  wire logic i_run,     // Run request asserted
  input  wire logic i_hold,    // Hold enable asserted
  input  wire logic i_clr,     // Clear wanted
  input  wire logic i_rot_lit, // Rotation indicator lit
  output logic      o_type_open,
  output logic      o_port_sel,
  output logic      o_run_req,
  output logic      o_hold_en,
  output logic      o_fault_clr
);
  // Polarity per wiring; clear waits for a dark rotation indicator
  always_comb begin
    o_type_open = i_contact;
    o_port_sel  = i_port ^ i_contact;
    o_run_req   = i_run ^ i_contact;
    o_hold_en   = i_hold ^ i_contact;
    o_fault_clr = (i_clr && !i_rot_lit) ^ i_contact;
  end
endmodule // rrc_far_side
`default_nettype wire

// ### testbench/rrc_remote_ctrl_assertions.sv
// Purpose: Port-level checks for the remote run control block.
// Assumes: One clock domain, reset active high.
// Notes:   Bound into the design from the bench top.
`default_nettype none
module rrc_remote_ctrl_assertions #(
  parameter logic [rrc_pkg::CNT_W-1:0] P_HOLD_CYC = rrc_pkg::HOLD_CYC
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_run_req,
  input wire logic i_fault_clr,
  input wire logic i_fault_event,
  input wire logic o_rotor_run,
  input wire logic o_fault_latched,
  input wire logic o_led_power,
  input wire logic o_led_rot_green,
  input wire logic o_led_rot_orange,
  input wire logic o_led_fail_red
);
  // ----------------------------------------
  // Pin ages, saturating; only a lower bound matters
  // ----------------------------------------
  logic [7:0] run_age; // Cycles since run pin moved
  logic [7:0] clr_age; // Cycles since clear pin moved
  logic       run_prv; // Last run pin level
  logic       clr_prv; // Last clear pin level
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      run_age <= 8'h00;
      clr_age <= 8'h00;
      run_prv <= 1'b0;
      clr_prv <= 1'b0;
    end else begin
      run_prv <= i_run_req;
      clr_prv <= i_fault_clr;
      run_age <= (run_prv != i_run_req) ? 8'h00 : run_age + 8'(run_age != 8'hff);
      clr_age <= (clr_prv != i_fault_clr) ? 8'h00 : clr_age + 8'(clr_age != 8'hff);
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_hit; i_fault_event; endsequence
  sequence s_latch; o_fault_latched && !o_rotor_run; endsequence
  property p_fault_stop; s_hit |=> s_latch; endproperty
  property p_no_run; o_fault_latched |-> !o_rotor_run; endproperty
  property p_power; !$past(i_sys_rst) |-> o_led_power; endproperty
  localparam logic [7:0] HOLD_FLOOR = (|P_HOLD_CYC[rrc_pkg::CNT_W-1:8]) ? 8'hff : P_HOLD_CYC[7:0]; // Ages saturate
  property p_start_hold; $rose(o_rotor_run) |-> run_age >= HOLD_FLOOR; endproperty
  property p_clr_hold; $fell(o_fault_latched) |-> clr_age >= HOLD_FLOOR; endproperty
  property p_rot_excl; !(o_led_rot_green && o_led_rot_orange); endproperty
  property p_orange; o_led_rot_orange |-> !(o_rotor_run && $past(o_rotor_run)); endproperty
  property p_green; o_led_rot_green |-> o_rotor_run || $past(o_rotor_run); endproperty
  property p_red; o_led_fail_red |-> o_fault_latched || $past(o_fault_latched); endproperty

  a_fault_stop: assert property (p_fault_stop) else $error("fault did not stop rotor");
  a_no_run: assert property (p_no_run) else $error("rotor driven in failure");
  a_power: assert property (p_power) else $error("power indicator dark");
  a_start_hold: assert property (p_start_hold) else $error("start before hold time");
  a_clr_hold: assert property (p_clr_hold) else $error("clear before hold time");
  a_rot_excl: assert property (p_rot_excl) else $error("rotation green and orange");
  a_orange: assert property (p_orange) else $error("orange while running");
  a_green: assert property (p_green) else $error("green while stopped");
  a_red: assert property (p_red) else $error("red without failure");
endmodule // rrc_remote_ctrl_assertions
`default_nettype wire

// ### testbench/rrc_remote_ctrl_tb.sv
// Purpose: Self-checking bench for the remote run control block.
// Assumes: Hold 20, long 60, window 30, flash 4 cycles.
// Notes:   Pin levels come from the far-side model.
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
`define LOOK(n, e, g) @(negedge i_clk); `CHK(n, e, g) @(posedge i_clk);
module rrc_remote_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk, i_sys_rst, psel, pen, pwr, pready, pslverr, rotor, fault, irq, er;
  logic        contact, port, run, hold, clr, fev, nop, p_type, p_port, p_run, p_hold, p_clr;
  logic        lpw, lrg, lro, lfr, lfo, warn;
  logic [1:0]  wcode, fcode;
  logic [7:0]  paddr;
  logic [15:0] speed;
  logic [31:0] pwdata, prdata, rd;
  int          n_errors, cmp_count, m_run, m_fault, k;

  rrc_remote_ctrl #(.P_HOLD_CYC(29'h14), .P_LONG_CYC(29'h3c), .P_PWRUP_CYC(29'h1e), .P_FLASH_CYC(29'h4)) i_dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_in_type_open(p_type), .i_port_sel(p_port),
    .i_run_req(p_run), .i_hold_en(p_hold), .i_fault_clr(p_clr), .i_fault_event(fev),
    .i_warning(warn), .i_warn_code(wcode), .i_fault_code(fcode), .i_speed_rpm(speed),
    .i_normal_op(nop), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_rotor_run(rotor), .o_fault_latched(fault), .o_led_power(lpw), .o_led_rot_green(lrg),
    .o_led_rot_orange(lro), .o_led_fail_orange(lfo), .o_led_fail_red(lfr), .o_irq(irq));
  rrc_far_side u_far (.i_contact(contact), .i_port(port), .i_run(run), .i_hold(hold), .i_clr(clr),
    .i_rot_lit(lrg | lro), .o_type_open(p_type), .o_port_sel(p_port), .o_run_req(p_run),
    .o_hold_en(p_hold), .o_fault_clr(p_clr));

  // ----------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // Whole run is under 1,000 cycles
  initial begin
    repeat (4000) @(posedge i_clk);
    n_errors++;
    report_and_stop();
  end
  task automatic report_and_stop();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // One APB transfer; answer taken only at the pready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Compare drive and failure state with the model
  task automatic chk();
    `LOOK("rotor", m_run[0], rotor)
    `LOOK("fault", m_fault[0], fault)
  endtask
  // Lit cycles of one indicator over a full 8-half-slot period
  task automatic lit32(input string nm, input int sel, input int e);
    int cnt;
    cnt = 0;
    repeat (32) begin
      @(negedge i_clk);
      cnt += (sel == 0) ? lrg : (sel == 1) ? lfo : lfr;
    end
    `CHK(nm, e, cnt)
    @(posedge i_clk);
  endtask
  // Bounded wait for the rotor to reach the model state
  task automatic wait_run(input int v, input int lim);
    m_run = v;
    for (k = 0; k < lim && rotor !== v[0]; k++) @(negedge i_clk);
    chk();
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hf105));
    {psel, pen, pwr, contact, clr, fev, nop, run, hold, warn} = '0;
    {paddr, speed, pwdata, wcode, fcode} = '0;
    {m_run, m_fault, n_errors, cmp_count} = '0;
    port = 1'b1;
    i_sys_rst = 1'b1;
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    hold <= 1'b1;
    @(posedge i_clk);
    run <= 1'b1;
    repeat (38) @(posedge i_clk);
    chk();
    wait_run(1, 40);
    `LOOK("power", 1'b1, lpw)
    apb(1'b0, rrc_pkg::OFS_CTRL, 32'h0);
    `CHK("ctrl", 32'h0, rd)
    apb(1'b0, rrc_pkg::OFS_IRQ_MASK, 32'h0);
    `CHK("mask", 32'h0, rd)
    apb(1'b0, rrc_pkg::OFS_IRQ_STAT, 32'h0);
    `CHK("stat", 32'h1, rd)
    `CHK("irq", 1'b0, irq)
    // Stop by hold, then a short pulse and a restart while coasting
    hold <= 1'b0;
    wait_run(0, 8);
    speed <= 16'(1 + $urandom_range(19_999));
    run <= 1'b0;
    repeat (4) @(posedge i_clk);
    `LOOK("orange", 1'b1, lro)
    hold <= 1'b1;
    repeat (3) @(posedge i_clk);
    run <= 1'b1;
    repeat (10) @(posedge i_clk);
    run <= 1'b0;
    repeat (25) @(posedge i_clk);
    chk();
    run <= 1'b1;
    wait_run(1, 30);
    lit32("green", 0, speed <= rrc_pkg::RPM_ONE ? 4 : speed <= rrc_pkg::RPM_TWO ? 8 : 12);
    nop <= 1'b1;
    repeat (3) @(posedge i_clk);
    `LOOK("green", 1'b1, lrg)
    apb(1'b0, rrc_pkg::OFS_STAT, 32'h0);
    `CHK("live", 32'h13, rd)
    // Level start, hold line ignored
    apb(1'b1, rrc_pkg::OFS_CTRL, 32'h1);
    hold <= 1'b0;
    repeat (6) @(posedge i_clk);
    chk();
    run <= 1'b0;
    wait_run(0, 8);
    run <= 1'b1;
    wait_run(1, 30);
    // Failure latches, blocks restart, raises the interrupt
    apb(1'b1, rrc_pkg::OFS_IRQ_MASK, 32'h4 | ($urandom & 32'hffff_fff0));
    fev <= 1'b1;
    @(posedge i_clk);
    fev <= 1'b0;
    m_run = 0;
    m_fault = 1;
    chk();
    `LOOK("irq", 1'b1, irq)
    `LOOK("red", 1'b1, lfr)
    repeat (30) @(posedge i_clk);
    chk();
    k = $urandom_range(3);
    fcode <= 2'(k);
    repeat (2) @(posedge i_clk);
    lit32("red", 2, k == 0 ? 32 : 4 * k);
    fcode <= 2'h0;
    apb(1'b0, rrc_pkg::OFS_IRQ_STAT, 32'h0);
    `CHK("stat", 32'h7, rd)
    apb(1'b1, rrc_pkg::OFS_IRQ_STAT, 32'hf);
    `LOOK("irq", 1'b0, irq)
    // Short clear ignored, full clear releases
    run <= 1'b0;
    speed <= 16'h0;
    clr <= 1'b1;
    repeat (10) @(posedge i_clk);
    clr <= 1'b0;
    repeat (25) @(posedge i_clk);
    chk();
    clr <= 1'b1;
    for (k = 0; k < 40 && fault !== 1'b0; k++) @(negedge i_clk);
    m_fault = 0;
    chk();
    clr <= 1'b0;
    `LOOK("red", 1'b0, lfr)
    apb(1'b0, rrc_pkg::OFS_IRQ_STAT, 32'h0);
    `CHK("stat", 32'h8, rd)
    k = $urandom_range(3);
    {warn, wcode} <= {1'b1, 2'(k)};
    repeat (2) @(posedge i_clk);
    lit32("warn", 1, k == 0 ? 16 : 4 * k);
    warn <= 1'b0;
    // Contact wiring; pins dead until the port is selected
    contact <= 1'b1;
    port <= 1'b0;
    run <= 1'b1;
    repeat (30) @(posedge i_clk);
    chk();
    port <= 1'b1;
    wait_run(1, 30);
    apb(1'b0, 8'h10, 32'h0);
    `CHK("err", 1'b1, er)
    `CHK("rdata", 32'h0, rd)
    run <= 1'b0;
    wait_run(0, 8);
    `LOOK("dark", 1'b0, lrg | lro)
    i_sys_rst <= 1'b1;
    `LOOK("power", 1'b0, lpw)
    report_and_stop();
  end
endmodule // rrc_remote_ctrl_tb

bind rrc_remote_ctrl rrc_remote_ctrl_assertions #(.P_HOLD_CYC(P_HOLD_CYC)) u_chk (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_run_req(i_run_req), .i_fault_clr(i_fault_clr), .i_fault_event(i_fault_event),
  .o_rotor_run(o_rotor_run), .o_fault_latched(o_fault_latched), .o_led_power(o_led_power),
  .o_led_rot_green(o_led_rot_green), .o_led_rot_orange(o_led_rot_orange), .o_led_fail_red(o_led_fail_red));
`default_nettype wire
